//--- hw/mbp_bitmap.sv
// Purpose: per-block plug state with range query and range update
// Assumes: range given as first block index and block count
// Notes:   no reset input other than system reset touches the bits
`timescale 1ns/1ps
module mbp_bitmap #(
  parameter int NUM_BLOCKS = 64,
  parameter int IW         = 6,
  parameter int CW         = 7
) (
  // clock and system reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // range and operation
  input  wire logic [IW-1:0] first_i,
  input  wire logic [15:0]   cnt_i,
  input  wire logic          set_i,
  input  wire logic          clr_i,
  input  wire logic          clr_all_i,
  // range status
  output logic               all_set_o,
  output logic               none_set_o,
  output logic [CW-1:0]      count_o
);

  logic [NUM_BLOCKS-1:0] plug_ff;
  logic [NUM_BLOCKS-1:0] in_rng;

  // index must reach every block and the count must hold a full map
  if (NUM_BLOCKS < 1 || (1 << IW) < NUM_BLOCKS || (1 << CW) <= NUM_BLOCKS) begin : g_chk
    $error("bitmap parameters inconsistent");
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
    // 32-bit compares avoid wrap when first+cnt passes the array end
    assign in_rng[i] = (32'(first_i) <= 32'(i)) &&
                       ((32'(i) - 32'(first_i)) < 32'(cnt_i));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        plug_ff[i] <= 1'b0;
      end else if (clr_all_i) begin
        plug_ff[i] <= 1'b0;
      end else if (set_i && in_rng[i]) begin
        plug_ff[i] <= 1'b1;
      end else if (clr_i && in_rng[i]) begin
        plug_ff[i] <= 1'b0;
      end
    end
  end

  assign all_set_o  = &(plug_ff | ~in_rng);
  assign none_set_o = ~|(plug_ff & in_rng);
  assign count_o    = CW'($countones(plug_ff));

endmodule

//--- hw/mbp_pkg.sv
// Purpose: shared constants for the memory block plug manager
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes:   sizes are kept in blocks inside and shown in bytes
package mbp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_REQ_TYPE   = 8'h00; // type lo16, padding hi16
  localparam logic [7:0] OFF_REQ_PAD    = 8'h04; // padding, accepted and dropped
  localparam logic [7:0] OFF_REQ_ADDR_L = 8'h08;
  localparam logic [7:0] OFF_REQ_ADDR_H = 8'h0C;
  localparam logic [7:0] OFF_REQ_NB     = 8'h10; // block count lo16, padding hi16
  localparam logic [7:0] OFF_REQ_PAD2   = 8'h14;
  localparam logic [7:0] OFF_CTRL       = 8'h18;
  localparam logic [7:0] OFF_STATUS     = 8'h1C;
  localparam logic [7:0] OFF_RESP_TYPE  = 8'h20;
  localparam logic [7:0] OFF_RESP_STATE = 8'h24;
  localparam logic [7:0] OFF_BLKSZ_L    = 8'h28;
  localparam logic [7:0] OFF_BLKSZ_H    = 8'h2C;
  localparam logic [7:0] OFF_NODE       = 8'h30;
  localparam logic [7:0] OFF_BASE_L     = 8'h34;
  localparam logic [7:0] OFF_BASE_H     = 8'h38;
  localparam logic [7:0] OFF_REGION_L   = 8'h3C;
  localparam logic [7:0] OFF_REGION_H   = 8'h40;
  localparam logic [7:0] OFF_USABLE_L   = 8'h44;
  localparam logic [7:0] OFF_USABLE_H   = 8'h48;
  localparam logic [7:0] OFF_PLUGGED_L  = 8'h4C;
  localparam logic [7:0] OFF_PLUGGED_H  = 8'h50;
  localparam logic [7:0] OFF_REQSZ_L    = 8'h54;
  localparam logic [7:0] OFF_REQSZ_H    = 8'h58;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_GO_BIT     = 0;
  localparam int CTRL_DEVRST_BIT = 1;
  localparam int CTRL_HOLD_BIT   = 2;
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_PEND_BIT   = 1;
  localparam int STAT_HOLD_BIT   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // encodings
  localparam logic [15:0] REQ_PLUG       = 16'h0000;
  localparam logic [15:0] REQ_UNPLUG     = 16'h0001;
  localparam logic [15:0] REQ_UNPLUG_ALL = 16'h0002;
  localparam logic [15:0] REQ_STATE      = 16'h0003;
  localparam logic [15:0] RESP_ACK       = 16'h0000;
  localparam logic [15:0] RESP_NACK      = 16'h0001;
  localparam logic [15:0] RESP_BUSY      = 16'h0002;
  localparam logic [15:0] RESP_ERROR     = 16'h0003;
  localparam logic [15:0] ST_PLUGGED     = 16'h0000;
  localparam logic [15:0] ST_UNPLUGGED   = 16'h0001;
  localparam logic [15:0] ST_MIXED       = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [15:0] RST_RESP_TYPE  = 16'h0000;

  typedef enum {MBP_IDLE, MBP_EXEC} mbp_state_t;

endpackage

//--- hw/mbp_top.sv
// Purpose: request engine and configuration space of a pluggable memory region
// Assumes: requests are written over Wishbone then started by a doorbell
// Notes:   one request in flight; answer is ready two cycles after the doorbell
// Functional notes
// - usable and requested size may change
// - block size, node, base, region fixed
// - plugged size equals plugged blocks total
// - usable size never below requested size
// - block size is a power of two
// - all sizes are block size multiples
// - usable shrinks only on unplug-all or reset
// - notify on usable/requested change, except unplug-all
// - device reset keeps every block state
// - request is 24 bytes, type then padding
// - request types plug0 unplug1 all2 state3
// - response is 10 bytes, type then padding
// - response types ack0 nack1 busy2 error3
// - plug/unplug carry address and block count
// - padding fields are ignored
// - misaligned, zero count, outside usable: error
// - plug of plugged, unplug of unplugged: error
// - busy when request cannot be served
// - success acknowledges and updates plugged size
// - unplug-all leaves plugged size zero
// - state query reports plugged, unplugged, mixed
`timescale 1ns/1ps
module mbp_top #(
  parameter int          NUM_BLOCKS   = 64,
  parameter int          BLOCK_SHIFT  = 21,
  parameter logic [63:0] REGION_BASE  = 64'h0000_0001_0000_0000,
  parameter logic [15:0] NODE_ID      = 16'h0000,
  parameter int          INIT_REQ     = 0,
  parameter int          INIT_USABLE  = 0
) (
  // clock and system reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // resize request from the managing side, in blocks
  input  wire logic        resize_valid_i,
  input  wire logic [15:0] resize_blocks_i,
  // configuration change notification
  output logic             cfg_change_o
);

  localparam int IW  = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
  localparam int CW  = $clog2(NUM_BLOCKS + 1);
  localparam logic [63:0] BLK_BYTES = 64'h1 << BLOCK_SHIFT;

  if (NUM_BLOCKS < 1 || NUM_BLOCKS > 4096) begin : g_chk_n
    $error("NUM_BLOCKS out of range");
  end
  if (BLOCK_SHIFT < 12 || BLOCK_SHIFT > 40) begin : g_chk_s
    $error("BLOCK_SHIFT out of range");
  end
  if ((REGION_BASE & (BLK_BYTES - 64'h1)) != 64'h0) begin : g_chk_b
    $error("REGION_BASE not block aligned");
  end
  if (INIT_REQ > NUM_BLOCKS || INIT_USABLE > NUM_BLOCKS ||
      INIT_USABLE < INIT_REQ) begin : g_chk_i
    $error("initial sizes inconsistent");
  end

  function automatic logic [63:0] to_bytes(input logic [CW-1:0] b);
    return 64'(b) << BLOCK_SHIFT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  mbp_pkg::mbp_state_t state_ff;
  logic [15:0]   rq_type_ff;
  logic [63:0]   rq_addr_ff;
  logic [15:0]   rq_nb_ff;
  logic          hold_ff;
  logic          done_ff;
  logic [15:0]   resp_type_ff;
  logic [15:0]   resp_state_ff;
  logic [CW-1:0] usable_ff;
  logic [CW-1:0] reqsz_ff;
  logic [CW-1:0] plugged_ff;
  logic          ack_ff;
  logic [31:0]   dat_ff;
  logic          notify_ff;

  logic          acc;
  logic          wr;
  logic          idle;
  logic          exec;
  logic [31:0]   nxt_rdata;
  logic          go;
  logic          devrst;

  assign acc    = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr     = acc && wb_we_i;
  assign idle   = (state_ff == mbp_pkg::MBP_IDLE);
  assign exec   = (state_ff == mbp_pkg::MBP_EXEC);
  assign devrst = wr && (wb_adr_i == mbp_pkg::OFF_CTRL) && wb_sel_i[0] &&
                  wb_dat_i[mbp_pkg::CTRL_DEVRST_BIT];
  assign go     = wr && (wb_adr_i == mbp_pkg::OFF_CTRL) && wb_sel_i[0] &&
                  wb_dat_i[mbp_pkg::CTRL_GO_BIT] && idle && !devrst;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request descriptor: only type, address and count are kept
  logic [31:0] m_type;
  logic [31:0] m_al;
  logic [31:0] m_ah;
  logic [31:0] m_nb;
  assign m_type = merge({16'h0000, rq_type_ff}, wb_dat_i, wb_sel_i);
  assign m_al   = merge(rq_addr_ff[31:0], wb_dat_i, wb_sel_i);
  assign m_ah   = merge(rq_addr_ff[63:32], wb_dat_i, wb_sel_i);
  assign m_nb   = merge({16'h0000, rq_nb_ff}, wb_dat_i, wb_sel_i);

  // padding words and upper halves are dropped here
  always_ff @(posedge clk_i) begin
    if (rst_i || devrst) begin
      rq_type_ff <= 16'h0000;
      rq_addr_ff <= 64'h0;
      rq_nb_ff   <= 16'h0000;
    end else if (wr && idle) begin
      if (wb_adr_i == mbp_pkg::OFF_REQ_TYPE) begin
        rq_type_ff <= m_type[15:0];
      end else if (wb_adr_i == mbp_pkg::OFF_REQ_ADDR_L) begin
        rq_addr_ff[31:0] <= m_al;
      end else if (wb_adr_i == mbp_pkg::OFF_REQ_ADDR_H) begin
        rq_addr_ff[63:32] <= m_ah;
      end else if (wb_adr_i == mbp_pkg::OFF_REQ_NB) begin
        rq_nb_ff <= m_nb[15:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff <= 1'b0;
    end else if (wr && wb_adr_i == mbp_pkg::OFF_CTRL && wb_sel_i[0]) begin
      hold_ff <= wb_dat_i[mbp_pkg::CTRL_HOLD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // range checks
  logic [63:0] off;
  logic [63:0] idx;
  logic [63:0] use64;
  logic        aligned;
  logic        rng_ok;
  logic        valid;
  logic        all_set;
  logic        none_set;
  logic [CW-1:0] bm_count;
  logic        plug_ok;
  logic        unplug_ok;
  logic        ua_go;
  logic [CW-1:0] nb_c;

  assign off     = rq_addr_ff - REGION_BASE;
  assign idx     = off >> BLOCK_SHIFT;
  assign use64   = 64'(usable_ff);
  assign aligned = (rq_addr_ff & (BLK_BYTES - 64'h1)) == 64'h0;
  assign rng_ok  = (rq_addr_ff >= REGION_BASE) && (idx < use64) &&
                   (64'(rq_nb_ff) <= use64 - idx);
  assign valid   = aligned && (rq_nb_ff != 16'h0000) && rng_ok;
  assign nb_c    = CW'(rq_nb_ff);

  assign plug_ok   = exec && rq_type_ff == mbp_pkg::REQ_PLUG && valid && !hold_ff &&
                     none_set && (32'(plugged_ff) + 32'(rq_nb_ff) <= 32'(reqsz_ff));
  assign unplug_ok = exec && rq_type_ff == mbp_pkg::REQ_UNPLUG && valid && !hold_ff &&
                     all_set;
  assign ua_go     = exec && rq_type_ff == mbp_pkg::REQ_UNPLUG_ALL;

  mbp_bitmap #(
    .NUM_BLOCKS (NUM_BLOCKS),
    .IW         (IW),
    .CW         (CW)
  ) u_bitmap (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .first_i    (idx[IW-1:0]),
    .cnt_i      (rq_nb_ff),
    .set_i      (plug_ok),
    .clr_i      (unplug_ok),
    .clr_all_i  (ua_go),
    .all_set_o  (all_set),
    .none_set_o (none_set),
    .count_o    (bm_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: doorbell, one execute cycle, answer
  always_ff @(posedge clk_i) begin
    if (rst_i || devrst) begin
      state_ff <= mbp_pkg::MBP_IDLE;
    end else begin
      case (state_ff)
        mbp_pkg::MBP_IDLE: begin
          if (go) begin
            state_ff <= mbp_pkg::MBP_EXEC;
          end
        end
        default: begin
          state_ff <= mbp_pkg::MBP_IDLE;
        end
      endcase
    end
  end

  // done is set by the answer and cleared by writing one; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i || devrst) begin
      done_ff <= 1'b0;
    end else if (exec) begin
      done_ff <= 1'b1;
    end else if (go || (wr && wb_adr_i == mbp_pkg::OFF_STATUS && wb_sel_i[0] &&
                        wb_dat_i[mbp_pkg::STAT_DONE_BIT])) begin
      done_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || devrst) begin
      resp_type_ff  <= mbp_pkg::RST_RESP_TYPE;
      resp_state_ff <= 16'h0000;
    end else if (exec) begin
      resp_state_ff <= 16'h0000;
      case (rq_type_ff)
        mbp_pkg::REQ_PLUG, mbp_pkg::REQ_UNPLUG: begin
          if (!valid) begin
            resp_type_ff <= mbp_pkg::RESP_ERROR;
          end else if (hold_ff) begin
            resp_type_ff <= mbp_pkg::RESP_BUSY;
          end else if (rq_type_ff == mbp_pkg::REQ_PLUG && !none_set) begin
            resp_type_ff <= mbp_pkg::RESP_ERROR;
          end else if (rq_type_ff == mbp_pkg::REQ_UNPLUG && !all_set) begin
            resp_type_ff <= mbp_pkg::RESP_ERROR;
          end else if (rq_type_ff == mbp_pkg::REQ_PLUG && !plug_ok) begin
            resp_type_ff <= mbp_pkg::RESP_NACK; // beyond requested size
          end else begin
            resp_type_ff <= mbp_pkg::RESP_ACK;
          end
        end
        mbp_pkg::REQ_UNPLUG_ALL: begin
          resp_type_ff <= mbp_pkg::RESP_ACK;
        end
        mbp_pkg::REQ_STATE: begin
          if (!valid) begin
            resp_type_ff <= mbp_pkg::RESP_ERROR;
          end else begin
            resp_type_ff <= mbp_pkg::RESP_ACK;
            if (all_set) begin
              resp_state_ff <= mbp_pkg::ST_PLUGGED;
            end else if (none_set) begin
              resp_state_ff <= mbp_pkg::ST_UNPLUGGED;
            end else begin
              resp_state_ff <= mbp_pkg::ST_MIXED;
            end
          end
        end
        default: begin
          resp_type_ff <= mbp_pkg::RESP_ERROR;
        end
      endcase
    end
  end

  // plugged size tracked as a block count; device reset leaves it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plugged_ff <= '0;
    end else if (ua_go) begin
      plugged_ff <= '0;
    end else if (plug_ok) begin
      plugged_ff <= plugged_ff + nb_c;
    end else if (unplug_ok) begin
      plugged_ff <= plugged_ff - nb_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sizes: requested follows the resize port, usable grows to cover it
  logic [CW-1:0] rs_blk;
  logic [CW-1:0] nxt_req;
  logic [CW-1:0] nxt_use;
  logic          nxt_notify;

  assign rs_blk = (32'(resize_blocks_i) > NUM_BLOCKS) ? CW'(NUM_BLOCKS)
                                                      : CW'(resize_blocks_i);

  always_comb begin
    nxt_req    = reqsz_ff;
    nxt_use    = usable_ff;
    nxt_notify = 1'b0;
    if (ua_go) begin
      nxt_use = reqsz_ff;
    end
    if (resize_valid_i) begin
      nxt_req = rs_blk;
    end
    if (nxt_use < nxt_req) begin
      nxt_use = nxt_req;
    end
    // a shrink from unplug-all alone stays silent
    if (nxt_req != reqsz_ff || (nxt_use > usable_ff) ||
        (nxt_use < usable_ff && !ua_go)) begin
      nxt_notify = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reqsz_ff  <= CW'(INIT_REQ);
      usable_ff <= CW'(INIT_USABLE);
      notify_ff <= 1'b0;
    end else begin
      reqsz_ff  <= nxt_req;
      usable_ff <= nxt_use;
      notify_ff <= nxt_notify;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; fixed values come from parameters only
  logic [63:0] region_b;
  assign region_b = 64'(NUM_BLOCKS) << BLOCK_SHIFT;

  always_comb begin
    nxt_rdata = mbp_pkg::RST_WORD;
    if (wb_adr_i == mbp_pkg::OFF_REQ_TYPE) begin
      nxt_rdata = {16'h0000, rq_type_ff};
    end else if (wb_adr_i == mbp_pkg::OFF_REQ_ADDR_L) begin
      nxt_rdata = rq_addr_ff[31:0];
    end else if (wb_adr_i == mbp_pkg::OFF_REQ_ADDR_H) begin
      nxt_rdata = rq_addr_ff[63:32];
    end else if (wb_adr_i == mbp_pkg::OFF_REQ_NB) begin
      nxt_rdata = {16'h0000, rq_nb_ff};
    end else if (wb_adr_i == mbp_pkg::OFF_CTRL) begin
      nxt_rdata = 32'(hold_ff) << mbp_pkg::CTRL_HOLD_BIT;
    end else if (wb_adr_i == mbp_pkg::OFF_STATUS) begin
      nxt_rdata = (32'(done_ff) << mbp_pkg::STAT_DONE_BIT) |
                  (32'(exec) << mbp_pkg::STAT_PEND_BIT) |
                  (32'(hold_ff) << mbp_pkg::STAT_HOLD_BIT);
    end else if (wb_adr_i == mbp_pkg::OFF_RESP_TYPE) begin
      nxt_rdata = {16'h0000, resp_type_ff};
    end else if (wb_adr_i == mbp_pkg::OFF_RESP_STATE) begin
      nxt_rdata = {16'h0000, resp_state_ff};
    end else if (wb_adr_i == mbp_pkg::OFF_BLKSZ_L) begin
      nxt_rdata = BLK_BYTES[31:0];
    end else if (wb_adr_i == mbp_pkg::OFF_BLKSZ_H) begin
      nxt_rdata = BLK_BYTES[63:32];
    end else if (wb_adr_i == mbp_pkg::OFF_NODE) begin
      nxt_rdata = {16'h0000, NODE_ID};
    end else if (wb_adr_i == mbp_pkg::OFF_BASE_L) begin
      nxt_rdata = REGION_BASE[31:0];
    end else if (wb_adr_i == mbp_pkg::OFF_BASE_H) begin
      nxt_rdata = REGION_BASE[63:32];
    end else if (wb_adr_i == mbp_pkg::OFF_REGION_L) begin
      nxt_rdata = region_b[31:0];
    end else if (wb_adr_i == mbp_pkg::OFF_REGION_H) begin
      nxt_rdata = region_b[63:32];
    end else if (wb_adr_i == mbp_pkg::OFF_USABLE_L) begin
      nxt_rdata = 32'(to_bytes(usable_ff));
    end else if (wb_adr_i == mbp_pkg::OFF_USABLE_H) begin
      nxt_rdata = 32'(to_bytes(usable_ff) >> 32);
    end else if (wb_adr_i == mbp_pkg::OFF_PLUGGED_L) begin
      nxt_rdata = 32'(to_bytes(plugged_ff));
    end else if (wb_adr_i == mbp_pkg::OFF_PLUGGED_H) begin
      nxt_rdata = 32'(to_bytes(plugged_ff) >> 32);
    end else if (wb_adr_i == mbp_pkg::OFF_REQSZ_L) begin
      nxt_rdata = 32'(to_bytes(reqsz_ff));
    end else if (wb_adr_i == mbp_pkg::OFF_REQSZ_H) begin
      nxt_rdata = 32'(to_bytes(reqsz_ff) >> 32);
    end
  end

  // every access, mapped or not, is acknowledged one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= mbp_pkg::RST_WORD;
    end else begin
      ack_ff <= acc;
      if (acc && !wb_we_i) begin
        dat_ff <= nxt_rdata;
      end
    end
  end

  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = dat_ff;
  assign cfg_change_o = notify_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CW-1:0] past_plug;
  always_ff @(posedge clk_i) begin
    past_plug <= plugged_ff;
  end

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_ff |=> !ack_ff) else $error("ack longer than one cycle");
  AST_PLUG_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    plugged_ff == bm_count) else $error("plugged size differs from block map");
  AST_USE_GE_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    usable_ff >= reqsz_ff) else $error("usable below requested");
  AST_NO_SHRINK: assert property (@(posedge clk_i) disable iff (rst_i)
    (usable_ff < $past(usable_ff)) |-> $past(ua_go)) else $error("usable shrank");
  AST_NOTIFY: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(reqsz_ff) || (usable_ff > $past(usable_ff))) |-> notify_ff)
    else $error("size change without notification");
  AST_DEVRST_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    devrst && !exec |=> plugged_ff == past_plug) else $error("device reset changed blocks");
  AST_ZERO_ERR: assert property (@(posedge clk_i) disable iff (rst_i || devrst)
    exec && rq_type_ff == mbp_pkg::REQ_PLUG && rq_nb_ff == 16'h0000
    |=> resp_type_ff == mbp_pkg::RESP_ERROR) else $error("zero count not refused");
  AST_DUP_ERR: assert property (@(posedge clk_i) disable iff (rst_i || devrst)
    exec && rq_type_ff == mbp_pkg::REQ_UNPLUG && valid && !hold_ff && !all_set
    |=> resp_type_ff == mbp_pkg::RESP_ERROR) else $error("double unplug not refused");
  AST_ACK_SIZE: assert property (@(posedge clk_i) disable iff (rst_i)
    plug_ok |=> plugged_ff == past_plug + nb_c && resp_type_ff == mbp_pkg::RESP_ACK)
    else $error("plug ack without size update");
  AST_UA_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    ua_go |=> plugged_ff == '0) else $error("unplug-all left blocks");
  AST_STATE_MIX: assert property (@(posedge clk_i) disable iff (rst_i || devrst)
    exec && rq_type_ff == mbp_pkg::REQ_STATE && valid && !all_set && !none_set
    |=> resp_state_ff == mbp_pkg::ST_MIXED) else $error("mixed state wrong");
  AST_ONE_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i || devrst)
    go |=> exec ##1 (idle && done_ff)) else $error("request not answered once");

  COV_PLUG_ACK: cover property (@(posedge clk_i) disable iff (rst_i) plug_ok);
  COV_UNPLUG_ALL: cover property (@(posedge clk_i) disable iff (rst_i) ua_go);
  COV_STATE_MIX: cover property (@(posedge clk_i) disable iff (rst_i)
    exec && rq_type_ff == mbp_pkg::REQ_STATE && valid && !all_set && !none_set);

endmodule

//--- verification/mbp_drv_model.sv
// Purpose: guest driver model, classic wishbone master
// Assumes: one transfer at a time, slave answers at its own pace
// Notes:   signals change only by nonblocking update after a rising edge
`timescale 1ns/1ps
module mbp_drv_model (
  // clock and slave answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // request
  output logic             cyc_o = 1'b0,
  output logic             we_o  = 1'b0,
  output logic [7:0]       adr_o = 8'h00,
  output logic [31:0]      dat_o = 32'h0000_0000
);
  // request held until ack, then released for a cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    // released data must not keep its last value
    dat_o <= ~d;
  endtask
endmodule

//--- verification/memory_block_plug_manager_tb.sv
// Purpose: self-checking bench for the memory block plug manager
// Assumes: usable 16 blocks and requested 8 blocks after reset
// Notes:   padding words and resize size are random, seed fixed
`timescale 1ns/1ps
module memory_block_plug_manager_tb;
  localparam logic [63:0] BSZ  = 64'h0000_0000_0020_0000;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_0000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, we, ack, cfg;
  logic        rv = 1'b0;
  logic        h  = 1'b0;
  logic [7:0]  adr;
  logic [31:0] wd, rd;
  logic [15:0] rb = 16'h0000;
  logic [15:0] r;
  logic [63:0] v;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          ncfg = 0;
  int          n;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (cfg === 1'b1) ncfg <= ncfg + 1;
  mbp_top #(.INIT_REQ(8), .INIT_USABLE(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .resize_valid_i(rv),
    .resize_blocks_i(rb), .cfg_change_o(cfg));
  mbp_drv_model u_drv (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc),
    .we_o(we), .adr_o(adr), .dat_o(wd));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [63:0] blk(input int b);
    return BASE + BSZ * 64'(b);
  endfunction
  task automatic rd64(input logic [7:0] a, output logic [63:0] q);
    u_drv.xfer(1'b0, a, 32'h0, q[31:0]);
    u_drv.xfer(1'b0, a + 8'h04, 32'h0, q[63:32]);
  endtask
  // one descriptor without the second padding word, with random padding, then poll for the answer
  task automatic run(input logic [15:0] t, input logic [63:0] a, input logic [15:0] nb,
                     input logic [15:0] ert, input logic [15:0] est, input int epl);
    logic [31:0] q;
    u_drv.xfer(1'b1, mbp_pkg::OFF_REQ_TYPE, {16'($urandom), t}, q);
    u_drv.xfer(1'b1, mbp_pkg::OFF_REQ_PAD, $urandom, q);
    u_drv.xfer(1'b1, mbp_pkg::OFF_REQ_ADDR_L, a[31:0], q);
    u_drv.xfer(1'b1, mbp_pkg::OFF_REQ_ADDR_H, a[63:32], q);
    u_drv.xfer(1'b1, mbp_pkg::OFF_REQ_NB, {16'($urandom), nb}, q);
    u_drv.xfer(1'b1, mbp_pkg::OFF_CTRL, {29'h0, h, 2'b01}, q);
    q = 32'h0;
    while (q[0] !== 1'b1) u_drv.xfer(1'b0, mbp_pkg::OFF_STATUS, 32'h0, q);
    u_drv.xfer(1'b0, mbp_pkg::OFF_RESP_TYPE, 32'h0, q);
    chk({48'h0, q[15:0]}, {48'h0, ert});
    u_drv.xfer(1'b0, mbp_pkg::OFF_RESP_STATE, 32'h0, q);
    if (t === 16'h3 && ert === 16'h0) chk({48'h0, q[15:0]}, {48'h0, est});
    rd64(mbp_pkg::OFF_PLUGGED_L, v);
    chk(v, BSZ * 64'(epl));
  endtask
  initial begin
    void'($urandom(86));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd64(mbp_pkg::OFF_BLKSZ_L, v);
    chk(v, BSZ);
    rd64(mbp_pkg::OFF_BASE_L, v);
    chk(v, BASE);
    rd64(mbp_pkg::OFF_REGION_L, v);
    chk(v, 64 * BSZ);
    rd64(mbp_pkg::OFF_USABLE_L, v);
    chk(v, 16 * BSZ);
    run(16'h0, blk(0), 16'h4, 16'h0, 16'h0, 4);
    run(16'h0, blk(2), 16'h2, 16'h3, 16'h0, 4);
    run(16'h0, blk(1) + 64'h1000, 16'h1, 16'h3, 16'h0, 4);
    run(16'h0, blk(5), 16'h0, 16'h3, 16'h0, 4);
    run(16'h0, blk(14), 16'h4, 16'h3, 16'h0, 4);
    run(16'h0, blk(4), 16'h8, 16'h1, 16'h0, 4);
    run(16'h3, blk(0), 16'h4, 16'h0, 16'h0, 4);
    run(16'h3, blk(0), 16'h8, 16'h0, 16'h2, 4);
    run(16'h3, blk(8), 16'h4, 16'h0, 16'h1, 4);
    h = 1'b1;
    run(16'h0, blk(8), 16'h1, 16'h2, 16'h0, 4);
    h = 1'b0;
    run(16'h1, blk(6), 16'h2, 16'h3, 16'h0, 4);
    run(16'h1, blk(0), 16'h2, 16'h0, 16'h0, 2);
    run(16'h4 + 16'($urandom_range(11)), blk(0), 16'h1, 16'h3, 16'h0, 2);
    u_drv.xfer(1'b1, mbp_pkg::OFF_STATUS, 32'h0000_0001, v[31:0]);
    u_drv.xfer(1'b0, mbp_pkg::OFF_STATUS, 32'h0000_0000, v[31:0]);
    chk(v & 64'h0000_0000_FFFF_FFFF, 64'h0);
    u_drv.xfer(1'b1, mbp_pkg::OFF_CTRL, 32'h0000_0002, v[31:0]);
    run(16'h3, blk(2), 16'h2, 16'h0, 16'h0, 2);
    n = ncfg;
    run(16'h2, blk(0), 16'h0, 16'h0, 16'h0, 0);
    rd64(mbp_pkg::OFF_USABLE_L, v);
    chk(v, 8 * BSZ);
    chk(64'(ncfg - n), 64'h0);
    r = 16'(9 + $urandom_range(7));
    rb <= r;
    rv <= 1'b1;
    @(posedge clk_i);
    rv <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({63'h0, ncfg > n}, 64'h1);
    rd64(mbp_pkg::OFF_REQSZ_L, v);
    chk(v, BSZ * 64'(r));
    rd64(mbp_pkg::OFF_USABLE_L, v);
    chk({63'h0, v >= BSZ * 64'(r)}, 64'h1);
    print_verdict;
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    fail_count++;
    print_verdict;
  end
endmodule
